// ---- core/mqrs_consts.svh ----
`ifndef MQRS_CONSTS_SVH
`define MQRS_CONSTS_SVH

// Read address bus layout
`define MQRS_ADDR_W        8
`define MQRS_QSEL_LSB      0
`define MQRS_QSEL_MSB      3
`define MQRS_NULL_BIT      4
`define MQRS_DEV_LSB       5
`define MQRS_DEV_MSB       7
`define MQRS_SECTOR_BIT    0

// Queue and data sizes
`define MQRS_NUM_Q         16
`define MQRS_QID_W         4
`define MQRS_DATA_W        36
`define MQRS_FLAG_W        8
`define MQRS_DEV_W         3

// Reset values
`define MQRS_RST_DEV_ID    3'h0

`endif

// ---- core/mqrs_pkg.sv ----
package mqrs_pkg;
    // Read selection state of the port
    typedef enum logic [1:0] {
        MQRS_IDLE   = 2'b00,
        MQRS_FALL   = 2'b01,
        MQRS_ACTIVE = 2'b10
    } mqrs_state_t;
endpackage

// ---- core/mqrs_sync2.sv ----
`timescale 1ns/1ps
`include "mqrs_consts.svh"
// Two-stage synchroniser for a pin level
module mqrs_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;   // First stage, read only by second
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_dout;

    ////////////////////////////////////////////////////////////////
    // Next values
    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule

// ---- core/mqrs_qdecode.sv ----
`timescale 1ns/1ps
`include "mqrs_consts.svh"
// Decodes a captured queue id into a one-hot select
module mqrs_qdecode
    import mqrs_pkg::*;
(
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // Selection in
    input  wire logic                       valid,
    input  wire logic [`MQRS_QID_W-1:0]     qid,
    // One-hot select out
    output logic      [`MQRS_NUM_Q-1:0]     onehot
);
    logic [`MQRS_NUM_Q-1:0] next_onehot;   // Decoded select

    ////////////////////////////////////////////////////////////////
    // Decode, all zero when no real queue selected
    always_comb begin
        next_onehot = '0;
        if (valid) begin
            next_onehot[qid] = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            onehot <= '0;
        end else begin
            onehot <= next_onehot;
        end
    end
endmodule

// ---- core/mqrs_read_select.sv ----
`timescale 1ns/1ps
`include "mqrs_consts.svh"
// Notes on behaviour
// - Eight-bit read address picks queue or sector
// - Low four bits pick one of sixteen
// - Bit four selects the null queue
// - Upper three bits must match device id
// - Queue address captured when address strobe high
// - Old queue word may leave on capture
// - New queue word falls through next edge
// - Strobed flag mode reuses address for sector
// - Sector selection matches upper bits to id
// - Bits four to one ignored for sector
// - Sector captured when flag strobe high
// - Read happens only with enable asserted
// - Queue selection ignores read enable
// - New queue data second cycle after select
// - Flag bus cycles without read enable
// - Read enable and output enable active low
module mqrs_read_select
    import mqrs_pkg::*;
(
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // Pins from the read-side controller
    input  wire logic [`MQRS_ADDR_W-1:0]    read_queue_address,
    input  wire logic                       read_address_strobe,
    input  wire logic                       flag_sector_strobe,
    input  wire logic                       read_enable_n,
    input  wire logic                       output_enable_n,
    input  wire logic                       direct_flag_mode,
    // Device settings
    input  wire logic [`MQRS_DEV_W-1:0]     device_id,
    input  wire logic                       program_done_out,
    // Queue store side
    input  wire logic [`MQRS_DATA_W-1:0]    queue_head_data,
    input  wire logic [`MQRS_NUM_Q-1:0]     queue_almost_empty_n,
    // Outputs
    output logic      [`MQRS_QID_W-1:0]     read_queue_id,
    output logic                            read_queue_valid,
    output logic      [`MQRS_NUM_Q-1:0]     read_queue_onehot,
    output logic                            read_pop,
    output logic      [`MQRS_DATA_W-1:0]    data_out,
    output logic                            data_out_en,
    output logic      [`MQRS_FLAG_W-1:0]    almost_empty_ready_flag_bus,
    output logic                            flag_sector
);
    ////////////////////////////////////////////////////////////////
    // Overview
    // The read-side controller drives its pins on this port from its
    // own logic, so each pin level passes two flip-flops first.
    // All pins travel through one synchroniser group, so that the
    // strobes and the address they qualify stay aligned cycle for cycle.
    // The cost is two cycles of latency on every request.
    // A queue select seen on the pins before edge N is taken at N+2.
    // The first word of the new queue then falls through at N+3.
    // Flag sector strobes follow the same two-cycle path.
    // Device id and the programming status are same-clock signals,
    // so they are read directly, without synchronisers.
    //
    // Hazards
    // The reader must keep the two strobes apart; when both arrive,
    // each group acts on its own strobe and no priority is applied.
    // The reader must hold off the address strobe until programming
    // completes; a strobe seen earlier is dropped, not deferred.
    // An id mismatch deselects this device, so that only one device
    // of an expanded group ever drives the shared output bus.
    //
    // Limitations
    // Output enable gates the drive flag only; data_out keeps its word.
    // The fall-through word is loaded without a pop, since the store
    // shows its head word until a pop consumes it.
    // Polled mode alternates the two flag groups on every clock.
    //
    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Group width: address bits plus five single-bit controls
    localparam int SW = `MQRS_ADDR_W + 5;
    logic [SW-1:0] pins_raw;          // Raw pin group
    logic [SW-1:0] pins_s;            // Synchronised pin group
    logic [`MQRS_ADDR_W-1:0] addr_s;  // Address after sync
    logic astb_s;                     // Address strobe after sync
    logic fstb_s;                     // Flag strobe after sync
    logic ren_n_s;                    // Read enable after sync
    logic oe_n_s;                     // Output enable after sync
    logic dmode_s;                    // Flag mode after sync

    assign pins_raw = {read_queue_address, read_address_strobe, flag_sector_strobe,
                       read_enable_n, output_enable_n, direct_flag_mode};
    assign {addr_s, astb_s, fstb_s, ren_n_s, oe_n_s, dmode_s} = pins_s;

    mqrs_sync2 #(.W(SW)) u_sync (
        .clock (clock),
        .rst   (rst),
        .din   (pins_raw),
        .dout  (pins_s)
    );

    ////////////////////////////////////////////////////////////////
    // Address helpers
    // Upper address bits name the device within an expanded group.
    // Both queue select and sector select use the same comparison,
    // so it lives in one function.
    function automatic logic id_match(input logic [`MQRS_ADDR_W-1:0] a,
                                      input logic [`MQRS_DEV_W-1:0]  id);
        id_match = (a[`MQRS_DEV_MSB:`MQRS_DEV_LSB] == id);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Queue selection state
    // Idle: no real queue of this device selected.
    // Fall: a queue was just taken; its head word loads next edge.
    // Active: the selected queue is read whenever enable is low.
    // A new select may arrive in any state and restarts the fall.
    // A null or foreign address returns the port to idle.
    mqrs_state_t            state;        // Read selection state
    mqrs_state_t            next_state;
    logic [`MQRS_QID_W-1:0] next_read_queue_id;
    logic                   next_read_queue_valid;
    logic                   sel_take;     // Queue select taken this edge

    // Next selection values
    always_comb begin
        next_state            = state;
        next_read_queue_id    = read_queue_id;
        next_read_queue_valid = read_queue_valid;
        // Strobe honoured only after programming, reader
        sel_take = astb_s && !program_done_out;
        if (sel_take) begin
            if (id_match(addr_s, device_id)) begin
                if (addr_s[`MQRS_NULL_BIT]) begin
                    next_read_queue_valid = 1'b0;
                    next_state            = MQRS_IDLE;
                end else begin
                    next_read_queue_id =
                        addr_s[`MQRS_QSEL_MSB:`MQRS_QSEL_LSB];
                    next_read_queue_valid = 1'b1;
                    next_state            = MQRS_FALL;
                end
            end else begin
                // Another device addressed, deselect here
                next_read_queue_valid = 1'b0;
                next_state            = MQRS_IDLE;
            end
        end else begin
            case (state)
                MQRS_IDLE:   next_state = MQRS_IDLE;
                MQRS_FALL:   next_state = MQRS_ACTIVE;
                MQRS_ACTIVE: next_state = MQRS_ACTIVE;
                default:     next_state = MQRS_IDLE;
            endcase
        end
    end

    // Selection registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state            <= MQRS_IDLE;
            read_queue_id    <= '0;
            read_queue_valid <= 1'b0;
        end else begin
            state            <= next_state;
            read_queue_id    <= next_read_queue_id;
            read_queue_valid <= next_read_queue_valid;
        end
    end

    // Registered one-hot select
    // Decoded from the next values, so it changes on the same edge
    // as the registered queue id and valid flag.
    mqrs_qdecode u_dec (
        .clock  (clock),
        .rst    (rst),
        .valid  (next_read_queue_valid),
        .qid    (next_read_queue_id),
        .onehot (read_queue_onehot)
    );

    ////////////////////////////////////////////////////////////////
    // Output data path
    // The output word is held between loads, so the reader sees a
    // stable word while enable is high.
    // A pop pulse lasts one cycle and names the queue in read_queue_id.
    // On a select edge the old queue may still be read, because the
    // data path looks at the state before the new selection.
    // The drive flag follows output enable and the valid selection.
    logic                    next_read_pop;
    logic [`MQRS_DATA_W-1:0] next_data_out;
    logic                    next_data_out_en;

    // Next output values
    always_comb begin
        next_read_pop    = 1'b0;
        next_data_out    = data_out;
        next_data_out_en = !oe_n_s && read_queue_valid;
        case (state)
            MQRS_FALL: begin
                // First word of new queue falls through
                next_data_out = queue_head_data;
            end
            MQRS_ACTIVE: begin
                // Old or current queue still readable on select edge
                if (!ren_n_s) begin
                    next_read_pop = 1'b1;
                    next_data_out = queue_head_data;
                end
            end
            MQRS_IDLE: begin
                next_read_pop = 1'b0;
            end
            default: begin
                next_read_pop = 1'b0;
            end
        endcase
    end

    // Output registers
    always_ff @(posedge clock) begin
        if (rst) begin
            read_pop    <= 1'b0;
            data_out    <= '0;
            data_out_en <= 1'b0;
        end else begin
            read_pop    <= next_read_pop;
            data_out    <= next_data_out;
            data_out_en <= next_data_out_en;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Flag sector selection and flag bus
    // Group zero holds queues seven to zero, group one the rest.
    // Strobed mode holds the chosen group until the next flag strobe.
    // Polled mode swaps groups every clock, with no strobe needed.
    // Read enable plays no part in either mode.
    // The flag bus is registered, so it trails the group by one edge.
    // Flags are active low, so the bus idles high after reset.
    logic                   next_flag_sector;
    logic [`MQRS_FLAG_W-1:0] next_flag_bus;

    // Next flag values, no read enable involved
    always_comb begin
        next_flag_sector = flag_sector;
        if (dmode_s) begin
            // Strobed mode: capture sector on flag strobe
            if (fstb_s && id_match(addr_s, device_id)) begin
                next_flag_sector = addr_s[`MQRS_SECTOR_BIT];
            end
        end else begin
            // Polled mode: alternate sectors every clock
            next_flag_sector = !flag_sector;
        end
        if (flag_sector) begin
            next_flag_bus = queue_almost_empty_n[`MQRS_NUM_Q-1:`MQRS_FLAG_W];
        end else begin
            next_flag_bus = queue_almost_empty_n[`MQRS_FLAG_W-1:0];
        end
    end

    // Flag registers
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_sector                 <= 1'b0;
            almost_empty_ready_flag_bus <= '1;
        end else begin
            flag_sector                 <= next_flag_sector;
            almost_empty_ready_flag_bus <= next_flag_bus;
        end
    end
endmodule

// ---- testbench/mqrs_read_select_props.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Port checker for the read select block
module mqrs_read_select_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Pins
    input wire logic [7:0]  read_queue_address,
    input wire logic        read_address_strobe,
    input wire logic        read_enable_n,
    input wire logic        output_enable_n,
    input wire logic        direct_flag_mode,
    input wire logic [2:0]  device_id,
    // Store side
    input wire logic [35:0] queue_head_data,
    input wire logic [15:0] queue_almost_empty_n,
    // Outputs
    input wire logic [3:0]  read_queue_id,
    input wire logic        read_queue_valid,
    input wire logic [15:0] read_queue_onehot,
    input wire logic        read_pop,
    input wire logic [35:0] data_out,
    input wire logic        data_out_en,
    input wire logic [7:0]  almost_empty_ready_flag_bus,
    input wire logic        flag_sector
);
    logic [2:0] age; // Edges since reset, saturating
    // Keeps past values clear of the reset window
    always_ff @(posedge clock) begin
        if (rst) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_onehot_match: assert property (
        read_queue_valid |-> read_queue_onehot == (16'h1 << read_queue_id))
        else $error("one-hot select differs from queue id");
    a_onehot_idle: assert property (
        !read_queue_valid |-> read_queue_onehot == 16'h0)
        else $error("one-hot select set without a queue");
    a_id_from_addr: assert property (
        (age == 3'h7 && $rose(read_queue_valid))
        |-> read_queue_id == $past(read_queue_address[3:0], 3))
        else $error("queue id differs from address");
    a_valid_match: assert property (
        (age == 3'h7 && $rose(read_queue_valid))
        |-> $past(read_queue_address[7:5], 3) == device_id && !$past(read_queue_address[4], 3))
        else $error("selection taken for other device or null");
    a_sel_strobe: assert property (
        (age == 3'h7 && $rose(read_queue_valid)) |-> $past(read_address_strobe, 3))
        else $error("selection taken without strobe");
    a_data_falls: assert property (
        (age == 3'h7 && $rose(read_queue_valid)) |=> data_out == $past(queue_head_data))
        else $error("first word did not fall through");
    a_pop_enable: assert property (
        (age == 3'h7 && read_pop) |-> !$past(read_enable_n, 3))
        else $error("pop without read enable");
    a_out_enable: assert property (
        (age == 3'h7 && data_out_en) |-> !$past(output_enable_n, 3))
        else $error("output driven without output enable");
    a_polled_cycle: assert property (
        (age == 3'h7 && !$past(direct_flag_mode, 2) && !$past(direct_flag_mode, 3)
         && !$past(direct_flag_mode, 4)) |-> flag_sector != $past(flag_sector))
        else $error("flag group did not alternate");
    a_flag_group: assert property (
        age == 3'h7 |-> almost_empty_ready_flag_bus == ($past(flag_sector)
        ? $past(queue_almost_empty_n[15:8]) : $past(queue_almost_empty_n[7:0])))
        else $error("flag bus shows wrong group");
endmodule
bind mqrs_read_select mqrs_read_select_props i_mqrs_read_select_props (
    .clock(clock), .rst(rst), .read_queue_address(read_queue_address),
    .read_address_strobe(read_address_strobe), .read_enable_n(read_enable_n),
    .output_enable_n(output_enable_n), .direct_flag_mode(direct_flag_mode),
    .device_id(device_id), .queue_head_data(queue_head_data),
    .queue_almost_empty_n(queue_almost_empty_n), .read_queue_id(read_queue_id),
    .read_queue_valid(read_queue_valid), .read_queue_onehot(read_queue_onehot),
    .read_pop(read_pop), .data_out(data_out), .data_out_en(data_out_en),
    .almost_empty_ready_flag_bus(almost_empty_ready_flag_bus), .flag_sector(flag_sector)
);

// ---- testbench/mqrs_store_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Queue store model behind the read port
module mqrs_store_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Selection and consume
    input  wire logic [3:0]  read_queue_id,
    input  wire logic        read_pop,
    // Head word and flags
    output logic      [35:0] queue_head_data,
    output logic      [15:0] queue_almost_empty_n
);
    logic [7:0] cnt [16]; // Words consumed per queue
    // Head word names its queue and depth
    assign queue_head_data = {read_queue_id, 24'h5a5a5a, cnt[read_queue_id]};
    assign queue_almost_empty_n = 16'h3cc5; // Fixed flag pattern
    // Advance a queue on each pop
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                cnt[i] <= 8'h0;
            end
        end else if (read_pop) begin
            cnt[read_queue_id] <= cnt[read_queue_id] + 8'h1;
        end
    end
endmodule

// ---- testbench/test_multiqueue_read_select.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Bench for the read select block
module test_multiqueue_read_select;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  addr  = 8'h0;  // Read address pins
    logic        astb  = 1'b0;  // Queue strobe
    logic        fstb  = 1'b0;  // Sector strobe
    logic        ren_n = 1'b1;
    logic        oe_n  = 1'b0;  // Output enable, low
    logic        pdone = 1'b0;  // Programming done, low
    logic        dmode = 1'b0;  // Direct flag mode
    logic [35:0] head, dout;
    logic [15:0] aen, qoh;
    logic [3:0]  qid;
    logic [7:0]  fbus;
    logic        qval, pop, doen, fsec;
    int          fail_count = 0;
    int          n_checks   = 0;
    int          pops       = 0;
    logic [7:0]  used [16] = '{default: 8'h0}; // Expected pops per queue
    always #2.5 clock = ~clock;
    always @(posedge clock) if (!rst && pop === 1'b1) pops++;
    mqrs_read_select i_mqrs_read_select (
        .clock(clock), .rst(rst), .read_queue_address(addr), .read_address_strobe(astb),
        .flag_sector_strobe(fstb), .read_enable_n(ren_n), .output_enable_n(oe_n),
        .direct_flag_mode(dmode), .device_id(3'h5), .program_done_out(pdone),
        .queue_head_data(head), .queue_almost_empty_n(aen), .read_queue_id(qid),
        .read_queue_valid(qval), .read_queue_onehot(qoh), .read_pop(pop), .data_out(dout),
        .data_out_en(doen), .almost_empty_ready_flag_bus(fbus), .flag_sector(fsec));
    mqrs_store_model i_mqrs_store_model (
        .clock(clock), .rst(rst), .read_queue_id(qid), .read_pop(pop),
        .queue_head_data(head), .queue_almost_empty_n(aen));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One-cycle strobe, then wait out sync and fall-through
    task automatic sel(input logic [7:0] a, input logic sector);
        addr = a;
        astb = !sector;
        fstb = sector;
        step(1);
        astb = 1'b0;
        fstb = 1'b0;
        step(4);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Every queue, back to back, no read enable
    task automatic t_select();
        for (int q = 0; q < 16; q++) begin
            sel({3'h5, 1'b0, q[3:0]}, 1'b0);
            chk(qval, 1'b1);
            chk(qid, q);
            chk(dout, {q[3:0], 24'h5a5a5a, used[q]});
            chk(doen, 1'b1);
        end
        chk(pops, 0);
        $display("t_select done");
    endtask
    // Null queue, foreign device, strobe before programming done
    task automatic t_deselect();
        pdone = 1'b1;
        sel(8'ha6, 1'b0);
        chk(qid, 4'hf);
        chk(qval, 1'b1);
        pdone = 1'b0;
        sel(8'hb2, 1'b0);
        chk(qval, 1'b0);
        sel(8'h42, 1'b0);
        chk(qval, 1'b0);
        $display("t_deselect done");
    endtask
    // Three reads, then the queue shows its advanced head
    task automatic t_read();
        sel(8'ha2, 1'b0);
        pops = 0;
        ren_n = 1'b0;
        step(3);
        ren_n = 1'b1;
        step(6);
        chk(pops, 3);
        used[2] = 8'h3;
        sel(8'ha7, 1'b0);
        sel(8'ha2, 1'b0);
        chk(dout, {4'h2, 24'h5a5a5a, 8'h3});
        oe_n = 1'b1;
        step(3);
        chk(doen, 1'b0);
        oe_n = 1'b0;
        step(3);
        chk(doen, 1'b1);
        $display("t_read done");
    endtask
    // Direct sector choice, ignored bits, foreign device
    task automatic t_sector();
        dmode = 1'b1;
        step(4);
        sel(8'ha1, 1'b1);
        chk(fsec, 1'b1);
        chk(fbus, 8'h3c);
        sel(8'hbe, 1'b1);
        chk(fbus, 8'hc5);
        sel(8'h41, 1'b1);
        chk(fsec, 1'b0);
        dmode = 1'b0;
        step(6);
        $display("t_sector done");
    endtask
    initial begin
        #100us;
        fail_count++;
        close_out();
    end
    initial begin
        step(8);
        rst = 1'b0;
        t_select();
        t_deselect();
        t_read();
        t_sector();
        close_out();
    end
endmodule
